// >>> rtl/pwc_capture_timer.sv
// Top of the pulse-width capture timer channel with its APB register file.
// Assumes APB master on SYS_CLK and a pin synchronous to SYS_CLK.
//
// Notes on behaviour
// - Counter advances each rising edge of the undivided peripheral clock.
// - Both prescale fields at 000b select the divide-by-one source.
// - Edge field 00b counts on the rising edge.
// - Counter overflow raises overflow request when its enable is set.
// - Capture at FFFFh copies count, raises capture, no overflow.
// - Capture mode copies counter into register A on both pin edges.
// - Each capture into register A raises capture request when enabled.
// - Writing 1 to the run bit starts the counter.
// - Run bit 0 halts the counter holding its value, unless clear select 001b clears it on a capture.
// - Protected writes take effect only while unlock bit is 1.
// - Capture request suppressed while its enable is 0.
// - Overflow request suppressed while its enable is 0.
// - Software may load the counter while it is stopped.
// - Software may write register A before capture starts.
// - I/O control 1010b makes register A a both-edge capture.
// - Clear select 001b clears counter on register A capture.
`timescale 1ns/1ns
`include "pwc_regs.svh"
module pwc_capture_timer
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        TIMER_INPUT_PIN_A,
  output logic             CAPTURE_A_INTERRUPT,
  output logic             OVERFLOW_INTERRUPT
);
  import pwc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  apb_req_type   req;
  cfg_type       cfg;
  bus_state_type state_r, state_nxt;
  logic          run_r, run_nxt;
  logic          unlock_r, unlock_nxt;
  logic [2:0]    psc_r, psc_nxt, psc2_r, psc2_nxt, clr_r, clr_nxt;
  logic [1:0]    edge_r, edge_nxt;
  logic [3:0]    ioctl_r, ioctl_nxt;
  logic          cap_en_r, cap_en_nxt;
  logic          ovf_en_r, ovf_en_nxt;
  logic [15:0]   channel_counter_r, channel_counter_nxt;
  logic [15:0]   general_capture_reg_a_r, general_capture_reg_a_nxt;
  logic          cap_irq_r, cap_irq_nxt;
  logic          ovf_irq_r, ovf_irq_nxt;
  logic [31:0]   prdata_r, prdata_nxt;
  logic          pready_r, pready_nxt;
  logic          pslverr_r, pslverr_nxt;
  logic          cap_seen_r, cap_seen_nxt;
  logic          ovf_seen_r, ovf_seen_nxt;
  logic          tick, rise, fall;
  logic          wr_go, rd_go, hit, capture, overflow;

  // Bus signals travel as one struct
  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};
  assign cfg = '{psc: psc_r, psc2: psc2_r, edge_sel: edge_r, clr_sel: clr_r, io_ctl: ioctl_r};

  // Address decode shared by read and write paths
  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `OFS_START) || (a == `OFS_UNLOCK) || (a == `OFS_CTRL) ||
                 (a == `OFS_IOCTL) || (a == `OFS_IRQEN) || (a == `OFS_COUNTER) ||
                 (a == `OFS_GENREG_A) || (a == `OFS_STATUS);
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  pwc_count_source u_src
  (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .cfg   (cfg),
    .tick  (tick)
  );

  pwc_edge_detect u_edge
  (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .pin   (TIMER_INPUT_PIN_A),
    .rise  (rise),
    .fall  (fall)
  );

  // ****************************************************************
  // APB slave: one wait state, answer in the second access cycle
  // ****************************************************************
  assign hit   = addr_known(req.paddr);
  assign wr_go = (state_r == ST_ANSWER) && req.psel && req.penable && req.pwrite;
  assign rd_go = (state_r == ST_ANSWER) && req.psel && req.penable && !req.pwrite;

  // Bus state and read data; PREADY rises one cycle after PENABLE
  always_comb
  begin
    state_nxt   = state_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    case (state_r)
      ST_IDLE:
      begin
        if (req.psel && req.penable && !pready_r)
        begin
          state_nxt   = ST_ANSWER;
          pready_nxt  = 1'b1;
          pslverr_nxt = !hit;
          prdata_nxt  = 32'h0000_0000;
          if (!req.pwrite)
          begin
            if (req.paddr == `OFS_START)
              prdata_nxt[`RUN_BIT] = run_r;
            else if (req.paddr == `OFS_UNLOCK)
              prdata_nxt[0] = unlock_r;
            else if (req.paddr == `OFS_CTRL)
              prdata_nxt[10:0] = {psc2_r, clr_r, edge_r, psc_r};
            else if (req.paddr == `OFS_IOCTL)
              prdata_nxt[3:0] = ioctl_r;
            else if (req.paddr == `OFS_IRQEN)
              prdata_nxt[`IRQEN_OVF_BIT:0] = {ovf_en_r, 3'h0, cap_en_r};
            else if (req.paddr == `OFS_COUNTER)
              prdata_nxt[15:0] = channel_counter_r;
            else if (req.paddr == `OFS_GENREG_A)
              prdata_nxt[15:0] = general_capture_reg_a_r;
            else if (req.paddr == `OFS_STATUS)
              prdata_nxt[1:0] = {ovf_seen_r, cap_seen_r};
          end
        end
      end
      ST_ANSWER:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Protected registers change only while unlocked; the unlock bit itself is always writable
  always_comb
  begin
    run_nxt    = run_r;
    unlock_nxt = unlock_r;
    psc_nxt    = psc_r;
    psc2_nxt   = psc2_r;
    edge_nxt   = edge_r;
    clr_nxt    = clr_r;
    ioctl_nxt  = ioctl_r;
    cap_en_nxt = cap_en_r;
    ovf_en_nxt = ovf_en_r;
    if (wr_go)
    begin
      if (req.paddr == `OFS_UNLOCK)
        unlock_nxt = req.pwdata[0];
      else if (req.paddr == `OFS_START)
        run_nxt = req.pwdata[`RUN_BIT];
      else if (req.paddr == `OFS_IRQEN)
      begin
        cap_en_nxt = req.pwdata[`IRQEN_CAP_BIT];
        ovf_en_nxt = req.pwdata[`IRQEN_OVF_BIT];
      end
      else if (req.paddr == `OFS_CTRL && unlock_r)
      begin
        psc_nxt  = req.pwdata[`CTRL_PSC_LO +: 3];
        edge_nxt = req.pwdata[`CTRL_EDGE_LO +: 2];
        clr_nxt  = req.pwdata[`CTRL_CLR_LO +: 3];
        psc2_nxt = req.pwdata[`CTRL_PSC2_LO +: 3];
      end
      else if (req.paddr == `OFS_IOCTL && unlock_r)
        ioctl_nxt = req.pwdata[3:0];
    end
  end

  // ****************************************************************
  // Counter, capture and interrupt requests
  // ****************************************************************
  assign capture  = (ioctl_r == `IO_CAP_BOTH) && (rise || fall);
  assign overflow = run_r && tick && (channel_counter_r == `CNT_MAX) && !capture;

  // Capture wins over a software load of register A in the same cycle
  always_comb
  begin
    channel_counter_nxt       = channel_counter_r;
    general_capture_reg_a_nxt = general_capture_reg_a_r;
    if (run_r && tick)
      channel_counter_nxt = channel_counter_r + 16'h0001;
    if (wr_go && unlock_r && !run_r && req.paddr == `OFS_COUNTER)
      channel_counter_nxt = req.pwdata[15:0];
    if (wr_go && unlock_r && req.paddr == `OFS_GENREG_A)
      general_capture_reg_a_nxt = req.pwdata[15:0];
    if (capture)
    begin
      general_capture_reg_a_nxt = channel_counter_r;
      if (clr_r == `CLR_BY_GRA)
        channel_counter_nxt = `CNT_ZERO;
    end
  end

  // Requests are one-cycle pulses; status bits are sticky, set wins over clear
  always_comb
  begin
    cap_irq_nxt  = capture && cap_en_r;
    ovf_irq_nxt  = overflow && ovf_en_r;
    cap_seen_nxt = cap_seen_r;
    ovf_seen_nxt = ovf_seen_r;
    if (wr_go && req.paddr == `OFS_STATUS)
    begin
      cap_seen_nxt = cap_seen_r & ~req.pwdata[0];
      ovf_seen_nxt = ovf_seen_r & ~req.pwdata[1];
    end
    if (capture)
      cap_seen_nxt = 1'b1;
    if (overflow)
      ovf_seen_nxt = 1'b1;
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      state_r                 <= ST_IDLE;
      pready_r                <= 1'b0;
      pslverr_r               <= 1'b0;
      prdata_r                <= 32'h0000_0000;
      run_r                   <= 1'b0;
      unlock_r                <= 1'b0;
      psc_r                   <= `PSC_DIV1;
      psc2_r                  <= `PSC_DIV1;
      edge_r                  <= `EDGE_RISE;
      clr_r                   <= 3'h0;
      ioctl_r                 <= `RST_IOCTL;
      cap_en_r                <= 1'b0;
      ovf_en_r                <= 1'b0;
      channel_counter_r       <= `CNT_ZERO;
      general_capture_reg_a_r <= `CNT_ZERO;
      cap_irq_r               <= 1'b0;
      ovf_irq_r               <= 1'b0;
      cap_seen_r              <= 1'b0;
      ovf_seen_r              <= 1'b0;
    end
    else
    begin
      state_r                 <= state_nxt;
      pready_r                <= pready_nxt;
      pslverr_r               <= pslverr_nxt;
      prdata_r                <= prdata_nxt;
      run_r                   <= run_nxt;
      unlock_r                <= unlock_nxt;
      psc_r                   <= psc_nxt;
      psc2_r                  <= psc2_nxt;
      edge_r                  <= edge_nxt;
      clr_r                   <= clr_nxt;
      ioctl_r                 <= ioctl_nxt;
      cap_en_r                <= cap_en_nxt;
      ovf_en_r                <= ovf_en_nxt;
      channel_counter_r       <= channel_counter_nxt;
      general_capture_reg_a_r <= general_capture_reg_a_nxt;
      cap_irq_r               <= cap_irq_nxt;
      ovf_irq_r               <= ovf_irq_nxt;
      cap_seen_r              <= cap_seen_nxt;
      ovf_seen_r              <= ovf_seen_nxt;
    end
  end

  assign PRDATA              = prdata_r;
  assign PREADY              = pready_r;
  assign PSLVERR             = pslverr_r;
  assign CAPTURE_A_INTERRUPT = cap_irq_r;
  assign OVERFLOW_INTERRUPT  = ovf_irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_run_count: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (run_r && tick && !capture && !(wr_go && req.paddr == `OFS_COUNTER))
      |=> channel_counter_r == $past(channel_counter_r) + 16'h0001)
    else $error("counter did not advance");
  a_stop_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (!run_r && !capture && !wr_go) |=> $stable(channel_counter_r))
    else $error("stopped counter moved");
  a_ovf_irq: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (run_r && tick && ovf_en_r && channel_counter_r == 16'hffff && !capture)
      |=> OVERFLOW_INTERRUPT ##0 channel_counter_r == 16'h0000)
    else $error("overflow request missing or no wrap");
  a_ffff_cap: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (capture && channel_counter_r == 16'hffff) |=> !OVERFLOW_INTERRUPT && general_capture_reg_a_r == 16'hffff)
    else $error("capture at max raised overflow");
  a_cap_copy: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (ioctl_r == 4'ha && (rise || fall)) |=> general_capture_reg_a_r == $past(channel_counter_r))
    else $error("capture value wrong");
  a_cap_irq: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    CAPTURE_A_INTERRUPT |-> $past(capture) && $past(cap_en_r))
    else $error("capture request without cause");
  a_lock_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (wr_go && !unlock_r && req.paddr == `OFS_IOCTL) |=> $stable(ioctl_r))
    else $error("locked write took effect");
  a_clr_cap: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (capture && clr_r == 3'h1) |=> channel_counter_r == 16'h0000)
    else $error("counter not cleared on capture");
  a_ovf_mask: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !ovf_en_r |=> !OVERFLOW_INTERRUPT)
    else $error("masked overflow request");
endmodule // pwc_capture_timer

// >>> rtl/pwc_regs.svh
// Register offsets, field positions, field codes and reset values of the capture timer.
// Assumes inclusion by the package and by modules that decode the APB map.
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_START      12'h000
`define OFS_UNLOCK     12'h004
`define OFS_CTRL       12'h008
`define OFS_IOCTL      12'h00c
`define OFS_IRQEN      12'h010
`define OFS_COUNTER    12'h014
`define OFS_GENREG_A   12'h018
`define OFS_STATUS     12'h01c

// ****************************************************************
// Field positions
// ****************************************************************
`define RUN_BIT        4
`define CTRL_PSC_LO    0
`define CTRL_EDGE_LO   3
`define CTRL_CLR_LO    5
`define CTRL_PSC2_LO   8
`define IRQEN_CAP_BIT  0
`define IRQEN_OVF_BIT  4

// ****************************************************************
// Field codes and reset values
// ****************************************************************
`define PSC_DIV1       3'h0
`define EDGE_RISE      2'h0
`define CLR_BY_GRA     3'h1
`define IO_CAP_BOTH    4'ha
`define CNT_MAX        16'hffff
`define CNT_ZERO       16'h0000
`define RST_CTRL       32'h0000_0000
`define RST_IOCTL      4'h0

`endif

// >>> rtl/pwc_pkg.sv
// Types shared by the capture timer modules.
// Assumes the constants header sits beside it.
`include "pwc_regs.svh"
package pwc_pkg;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  // Channel configuration decoded from the control registers
  typedef struct packed {
    logic [2:0] psc;
    logic [2:0] psc2;
    logic [1:0] edge_sel;
    logic [2:0] clr_sel;
    logic [3:0] io_ctl;
  } cfg_type;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ANSWER = 2'b10
  } bus_state_type;

endpackage

// >>> rtl/pwc_edge_detect.sv
// Edge detector of the timer input pin.
// Assumes the pin is already synchronous to SYS_CLK.
`timescale 1ns/1ns
module pwc_edge_detect
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  import pwc_pkg::*;

  logic pin_r;
  logic pin_nxt;

  // Previous level of the pin
  always_comb
  begin
    pin_nxt = pin;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pin_r <= 1'b0;
    else
      pin_r <= pin_nxt;
  end

  // Edges are combinational so a capture lands on the edge's own cycle
  assign rise = pin & ~pin_r;
  assign fall = ~pin & pin_r;
endmodule // pwc_edge_detect

// >>> rtl/pwc_count_source.sv
// Count-enable source: prescale and edge selection.
// Assumes the peripheral clock A is SYS_CLK itself.
`timescale 1ns/1ns
`include "pwc_regs.svh"
module pwc_count_source
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire pwc_pkg::cfg_type cfg,
  output logic                  tick
);
  import pwc_pkg::*;

  logic src_ok;

  // Only undivided clock with rising edge is built; other codes hold the counter
  always_comb
  begin
    src_ok = (cfg.psc == `PSC_DIV1) && (cfg.psc2 == `PSC_DIV1)
             && (cfg.edge_sel == `EDGE_RISE);
  end

  assign tick = src_ok;

  a_tick_src: assert property (@(posedge clk) disable iff (!rst_n)
    tick |-> (cfg.psc == 3'h0 && cfg.psc2 == 3'h0 && cfg.edge_sel == 2'h0))
    else $error("count tick with non-default source");
endmodule // pwc_count_source

// >>> verif/pwc_pulse_source.sv
// Pulse source model that drives the timer input pin of the capture channel.
// Assumes a start request from the bench, synchronous to the same clock as the channel.
`timescale 1ns/1ns
module pwc_pulse_source
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        toggle_mode,
  input  wire logic [15:0] len,
  output logic             pin,
  output logic             busy
);
  logic [15:0] cnt_r;

  // ****************************************************************
  // Pin sequencer
  // ****************************************************************
  // Pulse mode: high for len cycles; toggle mode: len edges one cycle apart, len even
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin   <= 1'b0;
      busy  <= 1'b0;
      cnt_r <= 16'h0000;
    end
    else if (start && !busy)
    begin
      busy  <= 1'b1;
      cnt_r <= len;
      pin   <= 1'b1;
    end
    else if (busy)
    begin
      if (cnt_r == 16'h0001)
      begin
        busy <= 1'b0;
        pin  <= 1'b0;            // Always returns low, so an idle pin is a known level
      end
      else
      begin
        cnt_r <= cnt_r - 16'h0001;
        if (toggle_mode)
          pin <= ~pin;
      end
    end
  end
endmodule // pwc_pulse_source

// >>> verif/tb.sv
// Self-checking bench of the capture timer: APB master, pulse source and event counters.
// Assumes the register offsets of the constants header and a one-clock design.
`timescale 1ns/1ns
`include "pwc_regs.svh"
module tb;
  logic        SYS_CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        PIN, CAP_IRQ, OVF_IRQ, src_start, src_tog, src_busy, slv_err;
  logic [15:0] src_len;
  logic [31:0] q, r1, r2;
  int          err_count, checks_done, base_c, base_o, w, i;
  int          cap_cnt = 0;
  int          ovf_cnt = 0;

  pwc_capture_timer u_dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TIMER_INPUT_PIN_A(PIN), .CAPTURE_A_INTERRUPT(CAP_IRQ),
    .OVERFLOW_INTERRUPT(OVF_IRQ));
  pwc_pulse_source u_src (.clk(SYS_CLK), .rst_n(RESET_N), .start(src_start), .toggle_mode(src_tog),
    .len(src_len), .pin(PIN), .busy(src_busy));

  // 250 MHz clock
  always #2 SYS_CLK = ~SYS_CLK;

  // Interrupt pulses are one cycle wide, so each high sample is one event
  always @(posedge SYS_CLK)
  begin
    if (CAP_IRQ === 1'b1) cap_cnt <= cap_cnt + 1;
    if (OVF_IRQ === 1'b1) ovf_cnt <= ovf_cnt + 1;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A bound that runs out is a mismatch and ends the run
  task automatic give_up(input string what);
    err_count++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    close_out();
  endtask

  // One APB transfer; request held until PREADY is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    @(posedge SYS_CLK);
    PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin @(posedge SYS_CLK); n++; end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) give_up("pready");
    rq = PRDATA; re = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x; logic e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
  endtask

  task automatic fire(input logic tog, input logic [15:0] n);
    @(posedge SYS_CLK);
    src_start <= 1'b1; src_tog <= tog; src_len <= n;
    @(posedge SYS_CLK);
    src_start <= 1'b0;
  endtask

  task automatic wait_cap(input int tgt);
    int n;
    for (n = 0; n < 2000 && cap_cnt < tgt; n++) @(posedge SYS_CLK);
    if (cap_cnt < tgt) give_up("capture wait");
  endtask

  task automatic load_run(input logic [31:0] cnt);
    wr(`OFS_START, 32'h0000_0000);
    wr(`OFS_COUNTER, cnt);
    wr(`OFS_START, 32'h0000_0010);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    SYS_CLK = 0; RESET_N = 0; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0; PWDATA = 0;
    src_start = 0; src_tog = 0; src_len = 0; err_count = 0; checks_done = 0;
    void'($urandom(96));
    repeat (12) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    // Reset values and the unmapped slot
    for (i = 0; i < 8; i++) begin rd(i * 4, q); chk("reset value", 32'h0, q); end
    apb(1'b0, 12'h020, 32'h0, q, slv_err);
    chk("unmapped error", 32'h1, {31'h0, slv_err});
    chk("unmapped data", 32'h0, q);
    $display("test reset done");
    // Locked writes are dropped, unlocked ones land while stopped
    wr(`OFS_COUNTER, 32'h1234); wr(`OFS_GENREG_A, 32'h55); wr(`OFS_CTRL, 32'h7);
    rd(`OFS_COUNTER, q); chk("locked counter", 32'h0, q);
    rd(`OFS_CTRL, q); chk("locked ctrl", 32'h0, q);
    wr(`OFS_IOCTL, 32'ha); rd(`OFS_IOCTL, q); chk("locked ioctl", 32'h0, q);
    wr(`OFS_UNLOCK, 32'h1);
    wr(`OFS_COUNTER, 32'h1234); rd(`OFS_COUNTER, q); chk("counter load", 32'h1234, q);
    wr(`OFS_GENREG_A, 32'h55); rd(`OFS_GENREG_A, q); chk("reg a load", 32'h55, q);
    $display("test lock done");
    // Run then stop: value frozen and moved
    load_run(32'h0); repeat (30) @(posedge SYS_CLK); wr(`OFS_START, 32'h0);
    rd(`OFS_COUNTER, r1); repeat (10) @(posedge SYS_CLK); rd(`OFS_COUNTER, r2);
    chk("stopped hold", r1, r2);
    chk("counted", 32'h1, {31'h0, r1 > 32'd30});
    // Other prescale and edge codes give no /1 rising count
    for (i = 0; i < 3; i++)
    begin
      wr(`OFS_CTRL, (i == 0) ? 32'h1 : (i == 1) ? 32'h100 : 32'h8);
      load_run(32'h0); repeat (20) @(posedge SYS_CLK); wr(`OFS_START, 32'h0);
      rd(`OFS_COUNTER, q); chk("other source", 32'h0, q);
    end
    wr(`OFS_CTRL, 32'h0);
    $display("test run done");
    // Both-edge capture measures the high time exactly
    wr(`OFS_IOCTL, 32'ha); wr(`OFS_IRQEN, 32'h11); load_run(32'h0);
    for (i = 0; i < 5; i++)
    begin
      w = (i == 0) ? 20 : 20 + $urandom % 300;
      base_c = cap_cnt;
      fire(1'b0, w[15:0]); wait_cap(base_c + 1); rd(`OFS_GENREG_A, r1);
      wait_cap(base_c + 2); rd(`OFS_GENREG_A, r2);
      chk("pulse width", w, {16'h0, r2[15:0] - r1[15:0]});
      repeat (4) @(posedge SYS_CLK);
      chk("capture irqs", base_c + 2, cap_cnt);
    end
    // Clear on capture: fall capture is width minus one
    wr(`OFS_CTRL, 32'h20); base_c = cap_cnt; fire(1'b0, 16'd40); wait_cap(base_c + 2);
    rd(`OFS_GENREG_A, q); chk("clear capture", 32'd39, q);
    wr(`OFS_CTRL, 32'h0); wr(`OFS_IOCTL, 32'h0); base_c = cap_cnt; fire(1'b0, 16'd20);
    repeat (30) @(posedge SYS_CLK); chk("no capture mode", base_c, cap_cnt);
    // Sticky status: captures seen, no wrap yet; write one clears
    rd(`OFS_STATUS, q); chk("status seen", 32'h1, q);
    wr(`OFS_STATUS, 32'h3); rd(`OFS_STATUS, q); chk("status clear", 32'h0, q);
    $display("test capture done");
    // Overflow wraps and keeps counting
    base_o = ovf_cnt; load_run(32'hfff0); repeat (40) @(posedge SYS_CLK); wr(`OFS_START, 32'h0);
    chk("overflow irq", base_o + 1, ovf_cnt);
    rd(`OFS_COUNTER, q); chk("wrapped", 32'h1, {31'h0, q > 32'd8 && q < 32'h40});
    // Captures every cycle across the wrap: FFFFh is captured, no overflow
    wr(`OFS_IOCTL, 32'ha); base_c = cap_cnt; base_o = ovf_cnt; load_run(32'hffe0);
    fire(1'b1, 16'd64); repeat (70) @(posedge SYS_CLK);
    chk("ffff no overflow", base_o, ovf_cnt);
    chk("burst captures", base_c + 64, cap_cnt);
    // Masked requests stay quiet
    wr(`OFS_IRQEN, 32'h0); base_c = cap_cnt; base_o = ovf_cnt; load_run(32'hfff0);
    fire(1'b0, 16'd20); repeat (60) @(posedge SYS_CLK);
    chk("masked capture", base_c, cap_cnt);
    chk("masked overflow", base_o, ovf_cnt);
    $display("test events done");
    close_out();
  end
endmodule // tb
